// ==== port_vbus_power_gating.sv ====
// Summary of operation
// - Request low while not a contracted sink switches the VBUS source enable off.
// - Once switched off by request, sourcing stays off until request rises again.
// - With insertion detect or micro-AB, request ignored unless a plug is inserted.
// - Controller enable output goes high to turn on the external port power controller.
// - Controller enable used only when the offered source capability is limited to 5 V.
// - With a charging controller, one enable turns on sourcing and handshake emulation.
// - Charging handshake completes before power delivery negotiation may begin.
// - In dedicated charging mode the handshake stays active after negotiation completes.
// - Reset input is active low and holds all port power logic in reset.
// - Low insertion detect input marks a standard-A plug as inserted.
`timescale 1ns/100ps

module port_vbus_power_gating (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RESETN,
    // Upstream request and plug presence
    input  wire logic UPSTREAM_PORT_POWER_REQUEST,
    input  wire logic INSERTION_DETECT_N,
    input  wire logic MICRO_A_PLUG_PRESENT,
    // Port status from the policy side
    input  wire logic SINK_CONTRACT_ACTIVE,
    input  wire logic NEGOTIATION_COMPLETE,
    // Static configuration straps
    input  wire logic INSERTION_DETECT_USED,
    input  wire logic MICRO_AB_RECEPTACLE,
    input  wire logic SOURCE_LIMITED_5V,
    input  wire logic CHARGING_CONTROLLER,
    input  wire logic DEDICATED_CHARGING_MODE,
    // Power path outputs
    output logic      VBUS_SOURCE_SWITCH_ENABLE,
    output logic      POWER_SWITCH_CONTROLLER_ENABLE,
    // Sequencing status
    output logic      HANDSHAKE_ACTIVE,
    output logic      NEGOTIATION_PERMIT
);

    logic [port_power_pkg::SYNC_W-1:0]   sync_in;
    logic [port_power_pkg::SYNC_W-1:0]   sync_q;
    logic                                req_s;
    logic                                insert_n_s;
    logic                                micro_a_s;
    logic                                sink_s;
    logic                                neg_done_s;
    logic                                plug_needed;
    logic                                plug_present;
    logic                                source_on;
    port_power_pkg::source_state_e       state_reg;
    port_power_pkg::source_state_e       state_next;
    logic [port_power_pkg::HS_CNT_W-1:0] hs_cnt_reg;
    logic [port_power_pkg::HS_CNT_W-1:0] hs_cnt_next;
    logic                                vbus_next;
    logic                                ctrl_next;
    logic                                hs_next;
    logic                                permit_next;

    // Gather asynchronous inputs for synchronisation
    always_comb begin
        sync_in = '0;
        sync_in[port_power_pkg::SYNC_POS_REQUEST]  = UPSTREAM_PORT_POWER_REQUEST;
        sync_in[port_power_pkg::SYNC_POS_INSERT_N] = INSERTION_DETECT_N;
        sync_in[port_power_pkg::SYNC_POS_MICRO_A]  = MICRO_A_PLUG_PRESENT;
        sync_in[port_power_pkg::SYNC_POS_SINK]     = SINK_CONTRACT_ACTIVE;
        sync_in[port_power_pkg::SYNC_POS_NEG_DONE] = NEGOTIATION_COMPLETE;
    end

    // Request and plug presence pass two flops before use
    input_sync #(
        .WIDTH     (port_power_pkg::SYNC_W),
        .RESET_VAL (port_power_pkg::SYNC_RESET)
    ) u_sync (
        .clk    (CLK),
        .resetn (RESETN),
        .d      (sync_in),
        .q      (sync_q)
    );

    // Split synchronised vector
    assign req_s      = sync_q[port_power_pkg::SYNC_POS_REQUEST];
    assign insert_n_s = sync_q[port_power_pkg::SYNC_POS_INSERT_N];
    assign micro_a_s  = sync_q[port_power_pkg::SYNC_POS_MICRO_A];
    assign sink_s     = sync_q[port_power_pkg::SYNC_POS_SINK];
    assign neg_done_s = sync_q[port_power_pkg::SYNC_POS_NEG_DONE];

    // Plug qualification of the request
    assign plug_needed  = INSERTION_DETECT_USED | MICRO_AB_RECEPTACLE;
    assign plug_present = (INSERTION_DETECT_USED & ~insert_n_s) | (MICRO_AB_RECEPTACLE & micro_a_s);

    // Sourcing decision and handshake sequencing
    always_comb begin
        vbus_next   = VBUS_SOURCE_SWITCH_ENABLE;
        state_next  = state_reg;
        hs_cnt_next = hs_cnt_reg;
        if (plug_needed && !plug_present) begin
            vbus_next = 1'b0;
        end else if (!req_s && !sink_s) begin
            vbus_next = 1'b0;
        end else if (req_s && !sink_s) begin
            vbus_next = 1'b1;
        end
        source_on = vbus_next;
        case (state_reg)
            port_power_pkg::ST_OFF: begin
                hs_cnt_next = port_power_pkg::HS_CNT_RESET;
                if (source_on && CHARGING_CONTROLLER) begin
                    state_next = port_power_pkg::ST_HANDSHAKE;
                end else if (source_on) begin
                    state_next = port_power_pkg::ST_NEGOTIATE;
                end
            end
            port_power_pkg::ST_HANDSHAKE: begin
                if (!source_on) begin
                    state_next = port_power_pkg::ST_OFF;
                end else if (hs_cnt_reg == port_power_pkg::HS_CNT_LAST) begin
                    state_next = port_power_pkg::ST_NEGOTIATE;
                end else begin
                    hs_cnt_next = hs_cnt_reg + 11'h001;
                end
            end
            port_power_pkg::ST_NEGOTIATE: begin
                if (!source_on) begin
                    state_next = port_power_pkg::ST_OFF;
                end
            end
            default: begin
                state_next = port_power_pkg::ST_OFF;
            end
        endcase
    end

    // Output next values
    always_comb begin
        ctrl_next   = source_on & SOURCE_LIMITED_5V;
        permit_next = (state_next == port_power_pkg::ST_NEGOTIATE);
        hs_next     = CHARGING_CONTROLLER & ctrl_next &
                      ((state_next == port_power_pkg::ST_HANDSHAKE) ||
                       ((state_next == port_power_pkg::ST_NEGOTIATE) &&
                        (!neg_done_s || DEDICATED_CHARGING_MODE)));
    end

    // Registers; reset drops every enable
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg                      <= port_power_pkg::ST_OFF;
            hs_cnt_reg                     <= port_power_pkg::HS_CNT_RESET;
            VBUS_SOURCE_SWITCH_ENABLE      <= 1'b0;
            POWER_SWITCH_CONTROLLER_ENABLE <= 1'b0;
            HANDSHAKE_ACTIVE               <= 1'b0;
            NEGOTIATION_PERMIT             <= 1'b0;
        end else begin
            state_reg                      <= state_next;
            hs_cnt_reg                     <= hs_cnt_next;
            VBUS_SOURCE_SWITCH_ENABLE      <= vbus_next;
            POWER_SWITCH_CONTROLLER_ENABLE <= ctrl_next;
            HANDSHAKE_ACTIVE               <= hs_next;
            NEGOTIATION_PERMIT             <= permit_next;
        end
    end

    // Low request while not a sink turns the source off next edge
    property p_req_low_off;
        @(posedge CLK) disable iff (!RESETN)
        (!req_s && !sink_s) |=> !VBUS_SOURCE_SWITCH_ENABLE;
    endproperty
    a_req_low_off: assert property (p_req_low_off) else $error("Source on after low request");

    // Source only rises after the request is seen high
    property p_stay_off;
        @(posedge CLK) disable iff (!RESETN)
        $rose(VBUS_SOURCE_SWITCH_ENABLE) |-> $past(req_s);
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("Source rose without request");

    // No plug means no sourcing
    property p_plug_gate;
        @(posedge CLK) disable iff (!RESETN)
        (plug_needed && !plug_present) |=> !VBUS_SOURCE_SWITCH_ENABLE;
    endproperty
    a_plug_gate: assert property (p_plug_gate) else $error("Source on without plug");

    // Insertion detect low with high request powers the port
    property p_insert_low;
        @(posedge CLK) disable iff (!RESETN)
        (INSERTION_DETECT_USED && !MICRO_AB_RECEPTACLE && !insert_n_s && req_s && !sink_s)
            |=> VBUS_SOURCE_SWITCH_ENABLE;
    endproperty
    a_insert_low: assert property (p_insert_low) else $error("Inserted plug not powered");

    // Controller enable follows sourcing, gated by the strap of the edge that loaded both
    property p_ctrl_follow;
        @(posedge CLK) disable iff (!RESETN)
        POWER_SWITCH_CONTROLLER_ENABLE == (VBUS_SOURCE_SWITCH_ENABLE && $past(SOURCE_LIMITED_5V));
    endproperty
    a_ctrl_follow: assert property (p_ctrl_follow) else $error("Controller enable mismatch");

    // Controller enable never high without the 5 V limit
    property p_ctrl_5v;
        @(posedge CLK) disable iff (!RESETN)
        !SOURCE_LIMITED_5V |=> !POWER_SWITCH_CONTROLLER_ENABLE;
    endproperty
    a_ctrl_5v: assert property (p_ctrl_5v) else $error("Controller enabled above 5 V");

    // Handshake only while the controller is enabled
    property p_hs_with_ppc;
        @(posedge CLK) disable iff (!RESETN)
        HANDSHAKE_ACTIVE |-> POWER_SWITCH_CONTROLLER_ENABLE;
    endproperty
    a_hs_with_ppc: assert property (p_hs_with_ppc) else $error("Handshake without controller");

    // Negotiation permit is preceded by handshake with a charging controller
    property p_hs_first;
        @(posedge CLK) disable iff (!RESETN)
        (CHARGING_CONTROLLER && $rose(NEGOTIATION_PERMIT)) |-> $past(HANDSHAKE_ACTIVE, 2);
    endproperty
    a_hs_first: assert property (p_hs_first) else $error("Negotiation before handshake");

    // Dedicated mode keeps handshake after negotiation completes
    property p_dedicated_hold;
        @(posedge CLK) disable iff (!RESETN)
        (NEGOTIATION_PERMIT && DEDICATED_CHARGING_MODE && CHARGING_CONTROLLER &&
         POWER_SWITCH_CONTROLLER_ENABLE && $stable(NEGOTIATION_PERMIT) && $stable(SOURCE_LIMITED_5V))
            |-> HANDSHAKE_ACTIVE;
    endproperty
    a_dedicated_hold: assert property (p_dedicated_hold) else $error("Handshake dropped in dedicated mode");

    // Enables held low during reset
    property p_reset_low;
        @(posedge CLK)
        !RESETN |-> (!VBUS_SOURCE_SWITCH_ENABLE && !POWER_SWITCH_CONTROLLER_ENABLE);
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("Enable high in reset");

    // Request change reaches the output three edges later
    property p_sync_delay;
        @(posedge CLK) disable iff (!RESETN)
        (!plug_needed && $fell(UPSTREAM_PORT_POWER_REQUEST) && !SINK_CONTRACT_ACTIVE)
            ##1 (!UPSTREAM_PORT_POWER_REQUEST && !SINK_CONTRACT_ACTIVE)[*2]
            |=> !VBUS_SOURCE_SWITCH_ENABLE;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("Request not synchronised as expected");

endmodule

// ==== port_power_pkg.sv ====
package port_power_pkg;

    // Clock period of CLK
    localparam int unsigned CLK_PERIOD_NS = 50;

    // Least time the charging handshake runs before negotiation may begin
    localparam int unsigned HANDSHAKE_TIME_NS = 100000;
    localparam int unsigned HANDSHAKE_CYCLES  =
        (HANDSHAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Handshake counter width and terminal value
    localparam int unsigned HS_CNT_W = 11;
    localparam logic [HS_CNT_W-1:0] HS_CNT_LAST = HS_CNT_W'(HANDSHAKE_CYCLES - 1);
    localparam logic [HS_CNT_W-1:0] HS_CNT_RESET = 11'h000;

    // Synchronised input vector layout
    localparam int unsigned SYNC_W            = 5;
    localparam int unsigned SYNC_POS_REQUEST  = 0;
    localparam int unsigned SYNC_POS_INSERT_N = 1;
    localparam int unsigned SYNC_POS_MICRO_A  = 2;
    localparam int unsigned SYNC_POS_SINK     = 3;
    localparam int unsigned SYNC_POS_NEG_DONE = 4;

    // Synchroniser reset value; the insertion detect bit idles high
    localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h02;

    // Sequencing of the sourcing path
    typedef enum logic [1:0] {
        ST_OFF,
        ST_HANDSHAKE,
        ST_NEGOTIATE
    } source_state_e;

endpackage

// ==== input_sync.sv ====
`timescale 1ns/100ps

module input_sync #(
    parameter int unsigned         WIDTH     = 1,
    parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Data
    input  wire logic [WIDTH-1:0]  d,
    output logic      [WIDTH-1:0]  q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_next;

    // Next values of the two stages; first stage feeds only the second
    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    // Two flip-flop synchroniser stages
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RESET_VAL;
            q        <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            q        <= q_next;
        end
    end

endmodule

// ==== upstream_request_model.sv ====
`timescale 1ns/100ps

module upstream_request_model (
    // Clock
    input  wire logic clk,
    // Request toward the port
    output logic      power_request
);
    // Upstream party starts by asking for the port off
    initial begin
        power_request = 1'b0;
    end

    // High allows port power, low asks it off; changes just after an edge
    task automatic set_request(input logic level);
        @(posedge clk);
        #1 power_request = level;
    endtask
endmodule

// ==== tb_port_vbus_power_gating.sv ====
`timescale 1ns/100ps

module tb_port_vbus_power_gating;
    // Stimulus, straps and observed outputs
    logic clk = 1'b0;
    logic resetn, ins_n, micro_a, sink, neg_done;
    logic ins_used, mab, lim5, chg, dcm;
    logic req, vbus, psc, hs, permit;
    int   err_total = 0;
    int   tests_run = 0;

    // Free running clock
    always #25 clk = ~clk;

    upstream_request_model model_u (
        .clk           (clk),
        .power_request (req)
    );

    port_vbus_power_gating dut_u (
        .CLK                            (clk),
        .RESETN                         (resetn),
        .UPSTREAM_PORT_POWER_REQUEST    (req),
        .INSERTION_DETECT_N             (ins_n),
        .MICRO_A_PLUG_PRESENT           (micro_a),
        .SINK_CONTRACT_ACTIVE           (sink),
        .NEGOTIATION_COMPLETE           (neg_done),
        .INSERTION_DETECT_USED          (ins_used),
        .MICRO_AB_RECEPTACLE            (mab),
        .SOURCE_LIMITED_5V              (lim5),
        .CHARGING_CONTROLLER            (chg),
        .DEDICATED_CHARGING_MODE        (dcm),
        .VBUS_SOURCE_SWITCH_ENABLE      (vbus),
        .POWER_SWITCH_CONTROLLER_ENABLE (psc),
        .HANDSHAKE_ACTIVE               (hs),
        .NEGOTIATION_PERMIT             (permit)
    );

    // Advance n edges, then step clear of the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Compare one observed bit against its expectation
    task automatic check(input string name, input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask

    // Print the counts and the verdict, then stop
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Latency, controller enable gating, switch off and staying off
    task automatic test_basic();
        lim5 = 1'b1;
        model_u.set_request(1'b1);
        step(2);
        check("vbus before sync", vbus, 1'b0);
        step(1);
        check("vbus on", vbus, 1'b1);
        check("ctrl on", psc, 1'b1);
        check("permit no chg", permit, 1'b1);
        check("no handshake", hs, 1'b0);
        lim5 = 1'b0;
        step(2);
        check("ctrl not 5v", psc, 1'b0);
        lim5 = 1'b1;
        model_u.set_request(1'b0);
        step(3);
        check("vbus off", vbus, 1'b0);
        step(20);
        check("vbus stays off", vbus, 1'b0);
        check("ctrl stays off", psc, 1'b0);
        model_u.set_request(1'b1);
        step(3);
        check("vbus back on", vbus, 1'b1);
        $display("test basic done");
    endtask

    // A contracted sink ignores a low request
    task automatic test_sink();
        sink = 1'b1;
        step(3);
        model_u.set_request(1'b0);
        step(5);
        check("vbus held as sink", vbus, 1'b1);
        sink = 1'b0;
        step(5);
        check("vbus off after sink", vbus, 1'b0);
        $display("test sink done");
    endtask

    // Plug qualification through insertion detect and micro-A
    task automatic test_plug();
        ins_used = 1'b1;
        model_u.set_request(1'b1);
        step(6);
        check("no plug", vbus, 1'b0);
        ins_n = 1'b0;
        step(2);
        check("plug in sync", vbus, 1'b0);
        step(1);
        check("plug in", vbus, 1'b1);
        ins_n = 1'b1;
        step(4);
        check("plug out", vbus, 1'b0);
        ins_used = 1'b0;
        mab = 1'b1;
        micro_a = 1'b1;
        step(4);
        check("micro-A in", vbus, 1'b1);
        micro_a = 1'b0;
        step(4);
        check("micro-A out", vbus, 1'b0);
        mab = 1'b0;
        step(4);
        check("no detection", vbus, 1'b1);
        $display("test plug done");
    endtask

    // Handshake before negotiation, kept in dedicated charging mode
    task automatic test_charge(input logic mode);
        model_u.set_request(1'b0);
        step(4);
        chg = 1'b1;
        dcm = mode;
        model_u.set_request(1'b1);
        step(3);
        check("vbus chg", vbus, 1'b1);
        check("handshake on", hs, 1'b1);
        check("ctrl chg", psc, 1'b1);
        check("permit early", permit, 1'b0);
        step(1990);
        check("permit still low", permit, 1'b0);
        step(15);
        check("permit high", permit, 1'b1);
        neg_done = 1'b1;
        step(4);
        check("handshake after neg", hs, mode);
        neg_done = 1'b0;
        model_u.set_request(1'b0);
        step(4);
        check("handshake off", hs, 1'b0);
        check("permit off", permit, 1'b0);
        chg = 1'b0;
        $display("test charge mode %b done", mode);
    endtask

    // Reset in mid-run clears both enables at once
    task automatic test_reset_mid();
        model_u.set_request(1'b1);
        step(4);
        check("vbus before reset", vbus, 1'b1);
        resetn = 1'b0;
        #1;
        check("vbus in reset", vbus, 1'b0);
        check("ctrl in reset", psc, 1'b0);
        step(3);
        resetn = 1'b1;
        step(1);
        check("vbus after release", vbus, 1'b0);
        step(4);
        check("vbus resumes", vbus, 1'b1);
        $display("test reset done");
    endtask

    // Main sequence
    initial begin
        resetn   = 1'b1;
        ins_n    = 1'b1;
        micro_a  = 1'b0;
        sink     = 1'b0;
        neg_done = 1'b0;
        ins_used = 1'b0;
        mab      = 1'b0;
        lim5     = 1'b0;
        chg      = 1'b0;
        dcm      = 1'b0;
        // A real falling edge just after time zero clears the outputs before the first clock
        #1 resetn = 1'b0;
        step(12);
        check("vbus at reset", vbus, 1'b0);
        check("ctrl at reset", psc, 1'b0);
        resetn = 1'b1;
        step(2);
        test_basic();
        test_sink();
        test_plug();
        test_charge(1'b0);
        test_charge(1'b1);
        test_reset_mid();
        complete_run();
    end

    // Watchdog, well beyond the length of the tests
    initial begin
        repeat (10000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        complete_run();
    end
endmodule
